// ==== csd_pkg.sv ====
/*
  Constants, register map and state type for the chip select and DRAM strobe unit.
  Assumes one system clock and a plain single-cycle register port with 16-bit data.
*/
package csd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  localparam int BASE_W = 10;
  localparam int CTL_W = 9;
  localparam int SIZE_W = 4;

  // Register offsets
  localparam logic [REG_AW-1:0] REG_UPPER_BASE = 4'h0;
  localparam logic [REG_AW-1:0] REG_UPPER_CTL = 4'h1;
  localparam logic [REG_AW-1:0] REG_LOWER_BASE = 4'h2;
  localparam logic [REG_AW-1:0] REG_LOWER_CTL = 4'h3;
  localparam logic [REG_AW-1:0] REG_MID_BASE = 4'h4;
  localparam logic [REG_AW-1:0] REG_MID_CTL = 4'h5;
  localparam logic [REG_AW-1:0] REG_PERIPH_BASE = 4'h6;
  localparam logic [REG_AW-1:0] REG_PERIPH_CTL = 4'h7;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;

  // Control register fields
  localparam int CTL_SIZE_LSB = 0;
  localparam int CTL_WIDE_BIT = 4;
  localparam int CTL_DRAM_BIT = 5;
  localparam int CTL_EN_BIT = 6;
  localparam int CTL_WHOLE_BIT = 7;
  localparam int CTL_IO_BIT = 8;

  // Base registers hold address bits 19..10, so regions are 1 Kbyte aligned
  localparam int BLOCK_SHIFT = 10;
  localparam logic [SIZE_W-1:0] SIZE_CODE_MAX = 4'h9;
  localparam int PERIPH_SUB_LSB = 7;

  localparam logic [ADDR_W-1:0] UPPER_RESET_ADDR = 20'hf_0000;
  localparam logic [BASE_W-1:0] UPPER_BASE_RST = UPPER_RESET_ADDR[ADDR_W-1:BLOCK_SHIFT];
  localparam logic [SIZE_W-1:0] UPPER_SIZE_RST = 4'h6;
  localparam logic [CTL_W-1:0] UPPER_CTL_RST = 9'h040 | 9'(UPPER_SIZE_RST);

  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Status register fields
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_STRAP_BIT = 1;
  localparam int STAT_UPPER_BIT = 2;
  localparam int STAT_LOWER_BIT = 3;

  typedef struct packed {
    logic [BASE_W-1:0] ubase;
    logic [BASE_W-1:0] lbase;
    logic [BASE_W-1:0] mbase;
    logic [BASE_W-1:0] pbase;
    logic [CTL_W-1:0] uctl;
    logic [CTL_W-1:0] lctl;
    logic [CTL_W-1:0] mctl;
    logic [CTL_W-1:0] pctl;
    logic [1:0] strap_sync;
    logic [1:0] strap_cnt;
    logic [3:0] mcs_pend;
    logic [7:0] pcs_pend;
    logic cas_pend;
    logic ucs;
    logic lower_region_select_n;
    logic [3:0] mcs;
    logic [7:0] pcs;
    logic oe_n;
    logic wide;
    logic [DATA_W-1:0] rdata;
  } csd_state_s;

  localparam csd_state_s STATE_RST = '{
    ubase: UPPER_BASE_RST,
    uctl: UPPER_CTL_RST,
    ucs: 1'b1,
    lower_region_select_n: 1'b1,
    mcs: 4'hf,
    pcs: 8'hff,
    oe_n: 1'b1,
    default: '0
  };
endpackage

// ==== csd_unit.sv ====
/*
  Chip select and DRAM strobe unit: decodes each bus cycle against four programmable
  regions and drives the shared select / strobe pins, with register port and strap.
  Assumes the bus cycle, hold and register inputs come from logic on CLOCK; only the
  strap arrives from a pin and is synchronised here.
*/
// Implementation choices: the register addresses and the address-and-strobe port.
module csd_unit
  import csd_pkg::*;
(
  input wire logic CLOCK, // System clock, 25 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic [REG_AW-1:0] REG_ADDR, // Register index
  input wire logic [DATA_W-1:0] REG_WDATA, // Register write data
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  output logic [DATA_W-1:0] REG_RDATA, // Read data, cycle after strobe
  input wire logic ACC_REQ, // Bus cycle in progress
  input wire logic [ADDR_W-1:0] ACC_ADDR, // Bus cycle address
  input wire logic ACC_IO, // Cycle is in I/O space
  input wire logic ACC_WRITE, // Cycle is a write
  input wire logic ACC_LO_BYTE, // Low byte enabled
  input wire logic ACC_HI_BYTE, // High byte enabled
  input wire logic HOLD_ACTIVE, // Bus granted to another master
  input wire logic UPPER_REGION_BYTE_WIDE_STRAP, // Strap pin, high for 8-bit boot
  output logic UPPER_REGION_SELECT_N, // Upper select pin
  output logic UPPER_REGION_SELECT_OE_N, // Its output enable, low drives
  output logic LOWER_REGION_SELECT_N, // Lower select or row strobe 0
  output logic LOWER_REGION_SELECT_OE_N, // Its output enable, low drives
  output logic [3:0] MIDRANGE_REGION_SELECT_N, // Midrange selects or DRAM strobes
  output logic [3:0] MIDRANGE_REGION_SELECT_OE_N, // Their output enables
  output logic [7:0] PERIPHERAL_REGION_SELECT_N, // Peripheral selects
  output logic [7:0] PERIPHERAL_REGION_SELECT_OE_N, // Their output enables
  output logic BUS_BYTE_WIDE // Current upper, lower or midrange region uses an 8-bit bus
);

  csd_state_s q;
  csd_state_s d;

  logic mem;
  logic busy;
  logic u_hit;
  logic l_hit;
  logic m_any;
  logic p_any;
  logic [3:0] m_sel;
  logic [7:0] p_sel;
  logic udram;
  logic ldram;
  logic cas_mode;
  logic cas_go;
  logic cas_lo_n;
  logic cas_hi_n;
  logic [3:0] mcs_now;

  // Block of 2^(code+10) bytes, aligned to its size
  function automatic logic region_hit(logic [ADDR_W-1:0] a, logic [BASE_W-1:0] base,
                                      logic [SIZE_W-1:0] code);
    logic [BASE_W-1:0] m;
    m = 10'h3ff << code;
    return ((a[ADDR_W-1:BLOCK_SHIFT] ^ base) & m) == 10'h000;
  endfunction

  // Each midrange subregion is a quarter of the block
  function automatic logic [1:0] mid_index(logic [ADDR_W-1:0] a, logic [SIZE_W-1:0] code);
    logic [ADDR_W-1:0] s;
    s = a >> (5'(code) + 5'd8);
    return s[1:0];
  endfunction

  // Sizes above 512 Kbyte would wrap the whole space, so they are clamped
  function automatic logic [CTL_W-1:0] ctl_write(logic [DATA_W-1:0] w);
    logic [CTL_W-1:0] c;
    c = w[CTL_W-1:0];
    if (c[SIZE_W-1:0] > SIZE_CODE_MAX) begin
      c[SIZE_W-1:0] = SIZE_CODE_MAX;
    end
    return c;
  endfunction

  always_comb begin
    d = q;
    mem = ACC_REQ && !ACC_IO;
    busy = ACC_REQ && !HOLD_ACTIVE;
    udram = q.uctl[CTL_DRAM_BIT];
    ldram = q.lctl[CTL_DRAM_BIT];
    cas_mode = udram || ldram;
    // Fixed priority keeps at most one region active if software overlaps them
    u_hit = mem && q.uctl[CTL_EN_BIT] &&
            region_hit(ACC_ADDR, q.ubase, q.uctl[SIZE_W-1:0]);
    l_hit = mem && q.lctl[CTL_EN_BIT] && !u_hit &&
            region_hit(ACC_ADDR, q.lbase, q.lctl[SIZE_W-1:0]);
    m_any = mem && q.mctl[CTL_EN_BIT] && !u_hit && !l_hit &&
            region_hit(ACC_ADDR, q.mbase, q.mctl[SIZE_W-1:0]);
    if (!m_any) begin
      m_sel = 4'h0;
    end else if (q.mctl[CTL_WHOLE_BIT]) begin
      m_sel = 4'h1;
    end else begin
      m_sel = 4'h1 << mid_index(ACC_ADDR, q.mctl[SIZE_W-1:0]);
    end
    p_any = ACC_REQ && (ACC_IO == q.pctl[CTL_IO_BIT]) && q.pctl[CTL_EN_BIT] &&
            !u_hit && !l_hit && !m_any && region_hit(ACC_ADDR, q.pbase, 4'h0);
    p_sel = p_any ? 8'h01 << ACC_ADDR[PERIPH_SUB_LSB+2:PERIPH_SUB_LSB] : 8'h00;

    // Multiplexed-bus selects wait one cycle for the address phase to pass
    d.mcs_pend = busy ? m_sel : 4'h0;
    d.pcs_pend = busy ? p_sel : 8'h00;
    d.cas_pend = busy && ((u_hit && udram) || (l_hit && ldram));
    cas_go = q.cas_pend && busy;
    cas_lo_n = !(cas_go && (!ACC_WRITE || ACC_LO_BYTE));
    cas_hi_n = !(cas_go && (!ACC_WRITE || ACC_HI_BYTE));
    mcs_now = q.mcs_pend & {4{busy}};

    // Upper pin idles while its region is DRAM; row strobe 1 moves to midrange pin 3
    d.ucs = !(busy && u_hit && !udram);
    d.lower_region_select_n = !(busy && l_hit);
    d.mcs[0] = !mcs_now[0];
    d.mcs[1] = cas_mode ? cas_hi_n : !mcs_now[1];
    d.mcs[2] = cas_mode ? cas_lo_n : !mcs_now[2];
    d.mcs[3] = udram ? !(busy && u_hit) : !mcs_now[3];
    d.pcs = ~(q.pcs_pend & {8{busy}});
    d.oe_n = HOLD_ACTIVE;

    if (!busy) begin
      d.wide = 1'b0;
    end else if (u_hit) begin
      d.wide = q.uctl[CTL_WIDE_BIT];
    end else if (l_hit) begin
      d.wide = q.lctl[CTL_WIDE_BIT];
    end else begin
      d.wide = m_any && q.mctl[CTL_WIDE_BIT];
    end

    if (REG_WR) begin
      unique case (REG_ADDR)
        REG_UPPER_BASE: d.ubase = REG_WDATA[BASE_W-1:0];
        REG_UPPER_CTL: d.uctl = ctl_write(REG_WDATA);
        REG_LOWER_BASE: d.lbase = REG_WDATA[BASE_W-1:0];
        REG_LOWER_CTL: d.lctl = ctl_write(REG_WDATA);
        REG_MID_BASE: d.mbase = REG_WDATA[BASE_W-1:0];
        REG_MID_CTL: d.mctl = ctl_write(REG_WDATA);
        REG_PERIPH_BASE: d.pbase = REG_WDATA[BASE_W-1:0];
        REG_PERIPH_CTL: d.pctl = ctl_write(REG_WDATA);
        default: d.ubase = q.ubase;
      endcase
    end

    // Strap is caught once the synchroniser has settled after reset release
    d.strap_sync = {q.strap_sync[0], UPPER_REGION_BYTE_WIDE_STRAP};
    if (q.strap_cnt != STRAP_SETTLE) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == STRAP_SETTLE - 2'h1) begin
        d.uctl[CTL_WIDE_BIT] = q.strap_sync[1];
      end
    end

    d.rdata = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_UPPER_BASE: d.rdata = DATA_W'(q.ubase);
        REG_UPPER_CTL: d.rdata = DATA_W'(q.uctl);
        REG_LOWER_BASE: d.rdata = DATA_W'(q.lbase);
        REG_LOWER_CTL: d.rdata = DATA_W'(q.lctl);
        REG_MID_BASE: d.rdata = DATA_W'(q.mbase);
        REG_MID_CTL: d.rdata = DATA_W'(q.mctl);
        REG_PERIPH_BASE: d.rdata = DATA_W'(q.pbase);
        REG_PERIPH_CTL: d.rdata = DATA_W'(q.pctl);
        REG_STATUS: begin
          d.rdata[STAT_HOLD_BIT] = q.oe_n;
          d.rdata[STAT_STRAP_BIT] = q.strap_cnt == STRAP_SETTLE;
          d.rdata[STAT_UPPER_BIT] = !q.ucs;
          d.rdata[STAT_LOWER_BIT] = !q.lower_region_select_n;
        end
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign UPPER_REGION_SELECT_N = q.ucs;
  assign UPPER_REGION_SELECT_OE_N = q.oe_n;
  assign LOWER_REGION_SELECT_N = q.lower_region_select_n;
  assign LOWER_REGION_SELECT_OE_N = q.oe_n;
  assign MIDRANGE_REGION_SELECT_N = q.mcs;
  assign MIDRANGE_REGION_SELECT_OE_N = {4{q.oe_n}};
  assign PERIPHERAL_REGION_SELECT_N = q.pcs;
  assign PERIPHERAL_REGION_SELECT_OE_N = {8{q.oe_n}};
  assign BUS_BYTE_WIDE = q.wide;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  sequence s_mid0_start;
    busy && m_sel[0] && !cas_mode;
  endsequence

  sequence s_mid_hold;
    busy;
  endsequence

  a_lower_float: assert property (HOLD_ACTIVE |=> LOWER_REGION_SELECT_OE_N && LOWER_REGION_SELECT_N)
    else $error("lower select driven during hold");
  a_mid_float: assert property (HOLD_ACTIVE |=> (MIDRANGE_REGION_SELECT_OE_N == 4'hf) && (MIDRANGE_REGION_SELECT_N == 4'hf))
    else $error("midrange selects driven during hold");
  a_periph_float: assert property (HOLD_ACTIVE |=> (PERIPHERAL_REGION_SELECT_OE_N == 8'hff) && (PERIPHERAL_REGION_SELECT_N == 8'hff))
    else $error("peripheral selects driven during hold");
  a_upper_float: assert property (HOLD_ACTIVE |=> UPPER_REGION_SELECT_OE_N && UPPER_REGION_SELECT_N)
    else $error("upper select driven during hold");
  a_upper_select: assert property (busy && u_hit && !udram |=> !UPPER_REGION_SELECT_N)
    else $error("upper select missed");
  a_lower_select: assert property (busy && l_hit |=> !LOWER_REGION_SELECT_N ##1 1'b1)
    else $error("lower select missed");
  a_mid_late_timing: assert property (s_mid0_start ##1 s_mid_hold |=> !MIDRANGE_REGION_SELECT_N[0])
    else $error("midrange select 0 not asserted one cycle late");
  a_mid_not_early: assert property ($rose(ACC_REQ) |=> (MIDRANGE_REGION_SELECT_N[0] && PERIPHERAL_REGION_SELECT_N == 8'hff))
    else $error("multiplexed select asserted in address phase");
  a_mid_whole_range: assert property (busy && m_any && q.mctl[CTL_WHOLE_BIT] ##1 busy |=> !MIDRANGE_REGION_SELECT_N[0])
    else $error("midrange select 0 ignored whole range option");
  a_cas_byte_lane: assert property (q.cas_pend && busy && ACC_WRITE && !ACC_LO_BYTE |=> MIDRANGE_REGION_SELECT_N[2])
    else $error("low column strobe on high byte write");
  a_row_strobe_one: assert property (busy && u_hit && udram |=> !MIDRANGE_REGION_SELECT_N[3] && UPPER_REGION_SELECT_N)
    else $error("row strobe 1 missing on upper DRAM access");
  a_strap_capture: assert property (q.strap_cnt == 2'h2 |=> q.uctl[CTL_WIDE_BIT] == $past(q.strap_sync[1]))
    else $error("strap not captured into upper width");
  a_boot_window: assert property (q.strap_cnt != STRAP_SETTLE && busy && !ACC_IO && ACC_ADDR[19:16] == 4'hf |=> !UPPER_REGION_SELECT_N)
    else $error("boot window not selected");

endmodule

// ==== csd_ext_bus.sv ====
/*
  Far side of the select pins: pullups seen by memories and peripherals.
  Assumes each enable is low while the unit drives its pin.
*/
module csd_ext_bus (
  input wire logic ucs_n, // Upper select pin
  input wire logic ucs_oe_n, // Its enable
  input wire logic lcs_n, // Lower select pin
  input wire logic lcs_oe_n, // Its enable
  input wire logic [3:0] mcs_n, // Midrange pins
  input wire logic [3:0] mcs_oe_n, // Their enables
  input wire logic [7:0] pcs_n, // Peripheral pins
  input wire logic [7:0] pcs_oe_n, // Their enables
  output logic [13:0] pins // Wire levels, upper first
);
  // A floating pin reads high, so hold and reset look idle to the devices
  always_comb begin
    pins[13] = ucs_oe_n ? 1'b1 : ucs_n;
    pins[12] = lcs_oe_n ? 1'b1 : lcs_n;
    for (int i = 0; i < 4; i++) begin
      pins[8+i] = mcs_oe_n[i] ? 1'b1 : mcs_n[i];
    end
    for (int i = 0; i < 8; i++) begin
      pins[i] = pcs_oe_n[i] ? 1'b1 : pcs_n[i];
    end
  end
endmodule

// ==== tb_csd_unit.sv ====
/*
  Self-checking bench for the chip select unit: table of decode cases, then
  reset, hold and timing cases. Assumes the register map and timing of the unit.
*/
module tb_csd_unit import csd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] ra; logic [15:0] rd; logic [19:0] a; logic [3:0] k;
    logic [13:0] sel; logic w;
  } csd_row_s;
  logic clock, rstn, reg_wr, reg_rd, acc_req, acc_io, acc_wr, acc_lo, acc_hi, hold, strap;
  logic [REG_AW-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [ADDR_W-1:0] acc_addr;
  logic ucs_n, ucs_oe_n, lcs_n, lcs_oe_n, wide;
  logic [3:0] mcs_n, mcs_oe_n;
  logic [7:0] pcs_n, pcs_oe_n;
  logic [13:0] pins;
  int miscompares, check_count;
  // Config write, access {io,wr,lo,hi}, wire levels {upper,lower,mid,periph}, width
  csd_row_s rows [18] = '{
    '{4'h8, 16'h0000, 20'hf_fff0, 4'h3, 14'h1fff, 1'b0},
    '{4'hf, 16'h0000, 20'he_fff0, 4'h3, 14'h3fff, 1'b0},
    '{4'h3, 16'h0056, 20'h0_1234, 4'h3, 14'h2fff, 1'b1},
    '{4'h8, 16'h0000, 20'h0_1234, 4'hb, 14'h3fff, 1'b0},
    '{4'h3, 16'h0046, 20'h0_ffff, 4'h3, 14'h2fff, 1'b0},
    '{4'h8, 16'h0000, 20'h1_0000, 4'h3, 14'h3fff, 1'b0},
    '{4'h4, 16'h0080, 20'h2_8000, 4'h3, 14'h3fff, 1'b0},
    '{4'h5, 16'h0046, 20'h2_8000, 4'h3, 14'h3bff, 1'b0},
    '{4'h5, 16'h0056, 20'h2_c000, 4'h3, 14'h37ff, 1'b1},
    '{4'h5, 16'h00c6, 20'h2_8000, 4'h3, 14'h3eff, 1'b0},
    '{4'h6, 16'h0100, 20'h4_0180, 4'hb, 14'h3fff, 1'b0},
    '{4'h7, 16'h0140, 20'h4_0180, 4'hb, 14'h3ff7, 1'b0},
    '{4'h8, 16'h0000, 20'h4_0180, 4'h3, 14'h3fff, 1'b0},
    '{4'h7, 16'h0040, 20'h4_0380, 4'h3, 14'h3f7f, 1'b0},
    '{4'h3, 16'h0066, 20'h0_1000, 4'h6, 14'h2bff, 1'b0},
    '{4'h8, 16'h0000, 20'h0_1000, 4'h5, 14'h2dff, 1'b0},
    '{4'h8, 16'h0000, 20'h0_1000, 4'h3, 14'h29ff, 1'b0},
    '{4'h1, 16'h0066, 20'hf_fff0, 4'h3, 14'h31ff, 1'b0}
  };

  csd_unit i_csd_unit (.CLOCK(clock), .RSTN(rstn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .ACC_REQ(acc_req), .ACC_ADDR(acc_addr), .ACC_IO(acc_io), .ACC_WRITE(acc_wr),
    .ACC_LO_BYTE(acc_lo), .ACC_HI_BYTE(acc_hi), .HOLD_ACTIVE(hold),
    .UPPER_REGION_BYTE_WIDE_STRAP(strap), .UPPER_REGION_SELECT_N(ucs_n),
    .UPPER_REGION_SELECT_OE_N(ucs_oe_n), .LOWER_REGION_SELECT_N(lcs_n),
    .LOWER_REGION_SELECT_OE_N(lcs_oe_n), .MIDRANGE_REGION_SELECT_N(mcs_n),
    .MIDRANGE_REGION_SELECT_OE_N(mcs_oe_n), .PERIPHERAL_REGION_SELECT_N(pcs_n),
    .PERIPHERAL_REGION_SELECT_OE_N(pcs_oe_n), .BUS_BYTE_WIDE(wide));
  csd_ext_bus i_csd_ext_bus (.ucs_n(ucs_n), .ucs_oe_n(ucs_oe_n), .lcs_n(lcs_n),
    .lcs_oe_n(lcs_oe_n), .mcs_n(mcs_n), .mcs_oe_n(mcs_oe_n), .pcs_n(pcs_n),
    .pcs_oe_n(pcs_oe_n), .pins(pins));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
    @(posedge clock);
    #1 chk("rdata idle", reg_rdata, 16'h0000);
  endtask
  // Drives a bus cycle and returns just after the edge that first samples it
  task automatic start(input logic [19:0] a, input logic [3:0] k);
    @(posedge clock);
    acc_req <= 1'b1;
    acc_addr <= a;
    {acc_io, acc_wr, acc_lo, acc_hi} <= k;
    @(posedge clock);
    #1;
  endtask
  task automatic idle();
    @(posedge clock);
    acc_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
  initial begin
    {rstn, reg_wr, reg_rd, acc_req, acc_io, acc_wr, acc_lo, acc_hi, hold, strap} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    acc_addr = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(REG_STATUS, 16'h0002);
    foreach (rows[i]) begin
      wr_reg(rows[i].ra, rows[i].rd);
      start(rows[i].a, rows[i].k);
      repeat (2) @(posedge clock);
      #1 chk("selects", {2'b00, pins}, {2'b00, rows[i].sel});
      chk("width", 16'(wide), 16'(rows[i].w));
      chk("enables", {2'b00, ucs_oe_n, lcs_oe_n, mcs_oe_n, pcs_oe_n}, 16'h0000);
      idle();
    end
    rd_reg(REG_LOWER_CTL, 16'h0066);
    rd_reg(4'hf, 16'h0000);
    // Second reset with an 8-bit boot strap
    @(posedge clock);
    rstn <= 1'b0;
    strap <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("reset pins", {2'b00, pins}, 16'h3fff);
    chk("reset enables", {2'b00, ucs_oe_n, lcs_oe_n, mcs_oe_n, pcs_oe_n}, 16'h3fff);
    @(posedge clock);
    rstn <= 1'b1;
    // Boot fetch starts before the strap is caught, so the reset window must already decode
    start(20'hf_0000, 4'h3);
    chk("upper early", 16'(pins[13]), 16'h0000);
    chk("boot width", 16'(wide), 16'h0000);
    repeat (2) @(posedge clock);
    #1 chk("upper width", 16'(wide), 16'h0001);
    rd_reg(REG_UPPER_CTL, 16'h0056);
    // Bus granted away in mid cycle: every pin floats back to its pullup
    @(posedge clock);
    hold <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("hold pins", {2'b00, pins}, 16'h3fff);
    chk("hold enables", {2'b00, ucs_oe_n, lcs_oe_n, mcs_oe_n, pcs_oe_n}, 16'h3fff);
    @(posedge clock);
    hold <= 1'b0;
    idle();
    wr_reg(REG_MID_BASE, 16'h0080);
    wr_reg(REG_MID_CTL, 16'h0046);
    start(20'h2_8000, 4'h3);
    chk("mid late", 16'(pins[11:8]), 16'h000f);
    @(posedge clock);
    #1 chk("mid select", 16'(pins[11:8]), 16'h000b);
    idle();
    #1 chk("mid released", 16'(pins[11:8]), 16'h000f);
    end_sim();
  end
endmodule
